// [hdl/tcp_timer_channels.sv]
// Four-channel 16-bit timer: counter, capture, compare, PWM and buffered pairs 0/1 and 2/3.
// Assumes control bits arrive as plain ports from a CPU-side register block.
//
// Overview of operation
// RL1: Active edge on capture channel copies counter into that channel's value register.
// RL2: Software picks rising, falling or both edges for each capture channel.
// RL3: A capture sets the channel flag, which can raise an interrupt.
// RL4: Counter equal to compare value sets, clears or toggles the pin as configured.
// RL5: A compare match sets the channel flag, which can raise an interrupt.
// RL6: Unbuffered value writes replace the compare value at once.
// RL7: Compare uses the value present at each count; late writes may miss.
// RL8: Software writes smaller unbuffered values from the channel compare interrupt.
// RL9: Software writes larger unbuffered values from the overflow interrupt.
// RL10: Compare interrupt comes at compare, overflow interrupt at period end.
// RL11: Pair 0/1 link bit makes one buffered channel on pin 0, channel 0 first.
// RL12: After a channel 1 write, it controls from next overflow; last written wins.
// RL13: While linked, channel 0 config rules, channel 1 unused, pin 1 released.
// RL14: Pair 2/3 link works the same on pin 2, channel 2 first.
// RL15: While linked, channel 2 config rules, channel 3 unused, pin 3 released.
// RL16: Software avoids writing the active register of a buffered pair.
// RL17: Toggle-on-overflow flips the pin at modulo match; period is overflow spacing. The code flips it one clock after rollover, as the count leaves zero.
// RL18: For PWM software picks clear or set on compare opposite the pulse level.
// RL19: Modulo 255 with no prescale gives a 256-clock period.
// RL20: Eight-bit period with value 128 gives a 50% duty.
// RL21: Software does not pick toggle-on-compare for PWM.
// RL22: Overflow flag sets when counter rolls to zero after modulo match.
// RL23: Link bit takes priority over the channel's other mode bit.
// RL24: With toggle-on-overflow clear, overflows cannot change the pin.
// RL25: Counter, modulo and values are 16 bits, compared in full.
`timescale 1ns/1ps
module tcp_timer_channels
	import tcp_pkg::*;
#(
	parameter int CNT_W = VAL_W
)
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CNT_RUN,
	input wire logic [CNT_W-1:0] MODULO,
	input tcp_chan_cfg_t [NUM_CH-1:0] CHAN_CFG,
	input wire logic OVF_IE,
	input wire logic OVF_CLR,
	input wire logic [NUM_CH-1:0] FLAG_CLR,
	input wire logic [NUM_CH-1:0] WR_EN,
	input wire logic [CNT_W-1:0] WR_DATA,
	input wire logic [NUM_CH-1:0] PIN_IN,
	output logic [NUM_CH-1:0] PIN_OUT,
	output logic [NUM_CH-1:0] PIN_OE_N,
	output logic [CNT_W-1:0] COUNT,
	output logic [NUM_CH-1:0][CNT_W-1:0] VALUE,
	output logic [NUM_CH-1:0] CHAN_FLAG,
	output logic [NUM_CH-1:0] CHAN_IRQ,
	output logic OVF_FLAG,
	output logic OVF_IRQ,
	output logic [NUM_PAIR-1:0] ACTIVE_SEL
);
	// RL25 full-width values
	initial
	begin
		if (CNT_W != VAL_W)
			$error("CNT_W must equal the 16-bit value width");
	end

	tcp_mode_t mode [NUM_CH];
	logic ovf;
	logic ovf_d;
	logic [NUM_CH-1:0] capture;
	logic [NUM_CH-1:0] match;
	logic [NUM_CH-1:0] pin_drv;
	logic [NUM_CH-1:0][CNT_W-1:0] cmp_val;
	logic [NUM_PAIR-1:0] last_wr;
	logic [NUM_PAIR-1:0] link_q;
	logic [NUM_CH-1:0] next_flag;

	// RL22 rollover to zero after modulo match
	assign ovf = CNT_RUN && (COUNT == MODULO);

	// RL19 period is modulo plus one clocks
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			COUNT <= CNT_RST;
		else if (ovf)
			COUNT <= CNT_RST;
		else if (CNT_RUN)
			COUNT <= COUNT + 1'b1;
	end

	// RL17 RL20 toggle one clock after the rollover edge
	// A toggle one clock after the modulo match keeps value 128 at exactly half a period
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			ovf_d <= 1'b0;
		else
			ovf_d <= ovf;
	end

	// RL22 overflow flag, set beats clear
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			OVF_FLAG <= 1'b0;
		else
			OVF_FLAG <= ovf | (OVF_FLAG & ~OVF_CLR);
	end

	// RL10 overflow request at period end
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			OVF_IRQ <= 1'b0;
		else
			OVF_IRQ <= (ovf | (OVF_FLAG & ~OVF_CLR)) & OVF_IE;
	end

	// Buffered pairs: which register of each pair drives the compare
	for (genvar p = 0; p < NUM_PAIR; p++)
	begin : g_pair
		always_ff @(posedge SYS_CLK)
		begin
			if (RST)
				link_q[p] <= 1'b0;
			else
				link_q[p] <= CHAN_CFG[2*p].link;
		end

		// RL12 last written register noted
		always_ff @(posedge SYS_CLK)
		begin
			if (RST || (CHAN_CFG[2*p].link && !link_q[p]))
				last_wr[p] <= SEL_EVEN;
			else if (WR_EN[2*p+1])
				last_wr[p] <= SEL_ODD;
			else if (WR_EN[2*p])
				last_wr[p] <= SEL_EVEN;
		end

		// RL11 RL14 even register controls first; RL12 switch only at overflow
		always_ff @(posedge SYS_CLK)
		begin
			if (RST || (CHAN_CFG[2*p].link && !link_q[p]))
				ACTIVE_SEL[p] <= SEL_EVEN;
			else if (ovf)
				ACTIVE_SEL[p] <= last_wr[p];
		end
	end

	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_chan
		// RL23 link priority
		assign mode[i] = tcp_chan_mode(i, CHAN_CFG);

		if (i % 2 == 0)
		begin : g_even
			assign cmp_val[i] = (mode[i] == MODE_BUFFERED && ACTIVE_SEL[i/2] == SEL_ODD) ?
				VALUE[i+1] : VALUE[i];
		end
		else
		begin : g_odd
			assign cmp_val[i] = VALUE[i];
		end

		// RL7 RL20 RL25 compare against the value present now, all 16 bits
		assign match[i] = CNT_RUN && (mode[i] == MODE_COMPARE || mode[i] == MODE_BUFFERED) &&
			(COUNT == cmp_val[i]);

		tcp_chan_pin u_pin (
			.clk(SYS_CLK),
			.rst(RST),
			.pin_in(PIN_IN[i]),
			.mode(mode[i]),
			.edge_sel(CHAN_CFG[i].edge_sel),
			.tov(CHAN_CFG[i].tov),
			.match(match[i]),
			.ovf(ovf_d),
			.capture(capture[i]),
			.pin_drv(pin_drv[i])
		);

		// RL1 capture wins over a same-cycle write; RL6 unbuffered write takes effect at once
		always_ff @(posedge SYS_CLK)
		begin
			if (RST)
				VALUE[i] <= VAL_RST;
			else if (capture[i])
				VALUE[i] <= COUNT;
			else if (WR_EN[i])
				VALUE[i] <= WR_DATA;
		end

		// RL3 RL5 flag on capture or compare; RL13 RL15 unused odd channel never sets a new flag but keeps one already set
		assign next_flag[i] = capture[i] | match[i] | (CHAN_FLAG[i] & ~FLAG_CLR[i]);

		always_ff @(posedge SYS_CLK)
		begin
			if (RST)
				CHAN_FLAG[i] <= 1'b0;
			else
				CHAN_FLAG[i] <= next_flag[i];
		end

		// RL10 channel request at the compare
		always_ff @(posedge SYS_CLK)
		begin
			if (RST)
				CHAN_IRQ[i] <= 1'b0;
			else
				CHAN_IRQ[i] <= next_flag[i] & CHAN_CFG[i].int_en;
		end

		// RL4 drive pin from channel level
		always_ff @(posedge SYS_CLK)
		begin
			if (RST)
				PIN_OUT[i] <= PIN_RST;
			else
				PIN_OUT[i] <= pin_drv[i];
		end

		// RL13 RL15 odd pin of a linked pair released for general use
		always_ff @(posedge SYS_CLK)
		begin
			if (RST)
				PIN_OE_N[i] <= 1'b1;
			else
				PIN_OE_N[i] <= !((mode[i] == MODE_COMPARE || mode[i] == MODE_BUFFERED) &&
					CHAN_CFG[i].edge_sel != ACT_NONE);
		end

		AST_CAPTURE_VALUE: assert property ( // RL1
			@(posedge SYS_CLK) disable iff (RST)
			capture[i] |=> VALUE[i] == $past(COUNT))
			else $error("captured value differs from counter");

		AST_EDGE_POLARITY: assert property ( // RL2
			@(posedge SYS_CLK) disable iff (RST)
			(mode[i] == MODE_CAPTURE && CHAN_CFG[i].edge_sel == EDGE_RISE && !PIN_IN[i]) |-> !capture[i])
			else $error("capture on unselected edge");

		AST_FLAG_IRQ: assert property ( // RL3
			@(posedge SYS_CLK) disable iff (RST)
			(capture[i] && CHAN_CFG[i].int_en) |=> CHAN_FLAG[i] && CHAN_IRQ[i])
			else $error("capture did not raise flag and request");

		AST_COMPARE_SET: assert property ( // RL4
			@(posedge SYS_CLK) disable iff (RST)
			(match[i] && CHAN_CFG[i].edge_sel == ACT_SET) |=> ##1 PIN_OUT[i])
			else $error("set on compare did not drive pin high");

		AST_COMPARE_FLAG: assert property ( // RL5
			@(posedge SYS_CLK) disable iff (RST)
			match[i] |=> CHAN_FLAG[i])
			else $error("compare match left flag clear");

		AST_WRITE_NOW: assert property ( // RL6
			@(posedge SYS_CLK) disable iff (RST)
			(WR_EN[i] && !capture[i]) |=> VALUE[i] == $past(WR_DATA))
			else $error("value write not taken at once");

		AST_TOV_OFF_LOW: assert property ( // RL24
			@(posedge SYS_CLK) disable iff (RST)
			(mode[i] == MODE_COMPARE && !CHAN_CFG[i].tov && CHAN_CFG[i].edge_sel == ACT_CLEAR && !pin_drv[i])
			|=> !pin_drv[i])
			else $error("pin rose with overflow toggles inhibited");
	end

	AST_ROLLOVER: assert property ( // RL19
		@(posedge SYS_CLK) disable iff (RST)
		ovf |=> COUNT == CNT_RST && OVF_FLAG)
		else $error("counter did not roll to zero with flag");

	AST_OVF_IRQ: assert property ( // RL22
		@(posedge SYS_CLK) disable iff (RST)
		(ovf && OVF_IE) |=> OVF_IRQ)
		else $error("overflow request missing");

	AST_ODD_RELEASED: assert property ( // RL13
		@(posedge SYS_CLK) disable iff (RST)
		$past(CHAN_CFG[0].link) |-> PIN_OE_N[1] && !CHAN_FLAG[1] || $past(CHAN_FLAG[1]))
		else $error("linked odd pin still driven");

	AST_BUF_SWITCH: assert property ( // RL12
		@(posedge SYS_CLK) disable iff (RST)
		(CHAN_CFG[0].link && link_q[0] && last_wr[0] == SEL_ODD && ovf) |=> ACTIVE_SEL[0] == SEL_ODD)
		else $error("buffered pair did not switch at overflow");

	AST_BUF_HOLD: assert property ( // RL11
		@(posedge SYS_CLK) disable iff (RST)
		(CHAN_CFG[0].link && link_q[0] && !ovf) |=> $stable(ACTIVE_SEL[0]))
		else $error("buffered pair switched away from overflow");

	AST_PAIR23_FIRST: assert property ( // RL14
		@(posedge SYS_CLK) disable iff (RST)
		(CHAN_CFG[2].link && !link_q[1]) |=> ACTIVE_SEL[1] == SEL_EVEN)
		else $error("pair 2/3 did not start on channel 2");

	AST_ODD3_QUIET: assert property ( // RL15
		@(posedge SYS_CLK) disable iff (RST)
		CHAN_CFG[2].link |-> !match[3] && !capture[3])
		else $error("unused channel 3 still active");
endmodule : tcp_timer_channels

// [inc/tcp_pkg.sv]
// Shared constants, types and mode decode for the four-channel capture/compare block.
// Assumes one clock domain; the counter advances once per clock while enabled.
package tcp_pkg;
	localparam int NUM_CH = 4;
	localparam int NUM_PAIR = 2;
	localparam int VAL_W = 16;
	localparam logic [VAL_W-1:0] CNT_RST = 16'h0000;
	localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
	localparam logic PIN_RST = 1'b0;
	localparam logic SEL_EVEN = 1'b0;
	localparam logic SEL_ODD = 1'b1;
	// Edge select field, input capture meaning
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Edge select field, output compare meaning
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;

	typedef struct packed {
		logic link;
		logic mode_low;
		logic [1:0] edge_sel;
		logic tov;
		logic int_en;
	} tcp_chan_cfg_t;

	typedef enum logic [4:0] {
		MODE_CAPTURE = 5'h01,
		MODE_COMPARE = 5'h02,
		MODE_BUFFERED = 5'h04,
		MODE_SLAVE = 5'h08,
		MODE_IDLE = 5'h10
	} tcp_mode_t;

	// Link bit of an even channel overrides its own mode bit and silences the odd partner
	function automatic tcp_mode_t tcp_chan_mode(input int ch, input tcp_chan_cfg_t [NUM_CH-1:0] cfg);
		tcp_mode_t m;
		m = MODE_IDLE;
		if (ch % 2 == 0 && cfg[ch].link)
			m = MODE_BUFFERED;
		else if (ch % 2 == 1 && cfg[ch-1].link)
			m = MODE_SLAVE;
		else if (cfg[ch].mode_low)
			m = MODE_COMPARE;
		else
			m = MODE_CAPTURE;
		return m;
	endfunction : tcp_chan_mode
endpackage : tcp_pkg

// [hdl/tcp_chan_pin.sv]
// One channel pin: capture edge detection and the compare-driven output level.
// Assumes the pin input is already synchronous to the clock.
`timescale 1ns/1ps
module tcp_chan_pin
	import tcp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic pin_in,
	input tcp_mode_t mode,
	input wire logic [1:0] edge_sel,
	input wire logic tov,
	input wire logic match,
	input wire logic ovf,
	output logic capture,
	output logic pin_drv
);
	logic pin_prev;
	logic armed;
	logic rise;
	logic fall;
	logic next_pin;

	// Armed flag keeps a high pin at reset release from reading as an edge
	always_ff @(posedge clk)
	begin
		if (rst)
			armed <= 1'b0;
		else
			armed <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		pin_prev <= pin_in;
	end

	assign rise = armed & pin_in & ~pin_prev;
	assign fall = armed & ~pin_in & pin_prev;
	// RL2 polarity select
	assign capture = (mode == MODE_CAPTURE) & ((edge_sel[0] & rise) | (edge_sel[1] & fall));

	always_comb
	begin
		next_pin = pin_drv;
		// RL17 toggle on overflow
		if (ovf && tov)
			next_pin = ~next_pin;
		// RL4 compare action; compare lands after the toggle so a clear at zero width holds low
		if (match)
		begin
			unique case (edge_sel)
				ACT_TOGGLE: next_pin = ~next_pin;
				ACT_CLEAR: next_pin = 1'b0;
				ACT_SET: next_pin = 1'b1;
				default: next_pin = next_pin;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pin_drv <= PIN_RST;
		else if (mode == MODE_COMPARE || mode == MODE_BUFFERED)
			pin_drv <= next_pin;
	end
endmodule : tcp_chan_pin

// [dv/tcp_pin_model.sv]
// Far side of the channel pins: external event sources sharing each pin wire.
// Assumes the bench moves the source levels on the falling clock edge.
`timescale 1ns/1ps
module tcp_pin_model
	import tcp_pkg::*;
(
	input wire logic [NUM_CH-1:0] src,
	input wire logic [NUM_CH-1:0] pin_out,
	input wire logic [NUM_CH-1:0] pin_oe_n,
	output logic [NUM_CH-1:0] pin_lvl
);
	// Design wins where it drives; a released pin follows the event source
	always_comb
		for (int i = 0; i < NUM_CH; i++)
			pin_lvl[i] = pin_oe_n[i] ? src[i] : pin_out[i];
endmodule : tcp_pin_model

// [dv/tcp_timer_channels_tb.sv]
// Self-checking bench for the four-channel capture/compare block.
// Assumes the pin model above; counter expectations come from a local model.
`timescale 1ns/1ps
module tcp_timer_channels_tb
	import tcp_pkg::*;
();
	typedef struct packed {logic [1:0] ch; logic [1:0] es; logic rise; logic cap;} tcp_row_t;
	tcp_row_t rows [8] = '{'{2'h0, EDGE_RISE, 1'h1, 1'h1}, '{2'h0, EDGE_RISE, 1'h0, 1'h0},
		'{2'h1, EDGE_FALL, 1'h0, 1'h1}, '{2'h1, EDGE_FALL, 1'h1, 1'h0}, '{2'h2, EDGE_BOTH, 1'h1, 1'h1},
		'{2'h2, EDGE_BOTH, 1'h0, 1'h1}, '{2'h3, EDGE_NONE, 1'h1, 1'h0}, '{2'h3, EDGE_RISE, 1'h1, 1'h1}};
	logic [1:0] acts [4] = '{ACT_SET, ACT_TOGGLE, ACT_SET, ACT_CLEAR};
	logic [3:0] pexp = 4'h5;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic run = 1'h0;
	logic ovf_ie = 1'h0;
	logic ovf_clr = 1'h0;
	logic [15:0] modulo = 16'h00ff;
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] cnt_m = 16'h0000;
	logic [15:0] exp_v;
	tcp_chan_cfg_t [NUM_CH-1:0] cfg = '0;
	logic [3:0] flag_clr = '0, wr_en = '0, src = '0, pin_in, pin_out, pin_oe_n, chan_flag, chan_irq;
	logic [15:0] count;
	logic [3:0][15:0] value;
	logic ovf_flag, ovf_irq, prev;
	logic [1:0] active_sel;
	int failures = 0, n_compared = 0, hi2, hi3, ups, e;

	always #12.5 sys_clk = ~sys_clk;

	tcp_timer_channels #(.CNT_W(16)) tcp_timer_channels_inst (.SYS_CLK(sys_clk), .RST(rst), .CNT_RUN(run),
		.MODULO(modulo), .CHAN_CFG(cfg), .OVF_IE(ovf_ie), .OVF_CLR(ovf_clr), .FLAG_CLR(flag_clr),
		.WR_EN(wr_en), .WR_DATA(wr_data), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
		.COUNT(count), .VALUE(value), .CHAN_FLAG(chan_flag), .CHAN_IRQ(chan_irq), .OVF_FLAG(ovf_flag),
		.OVF_IRQ(ovf_irq), .ACTIVE_SEL(active_sel));
	tcp_pin_model tcp_pin_model_inst (.src(src), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_lvl(pin_in));

	// Reference counter: wraps to zero the clock after it equals the modulo
	always @(posedge sys_clk)
		if (rst)
			cnt_m <= 16'h0000;
		else if (run)
			cnt_m <= (cnt_m == modulo) ? 16'h0000 : cnt_m + 16'h0001;

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] expv);
		n_compared++;
		if (seen !== expv)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, expv, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	// Bounded wait for the model count; a lost counter ends the run
	task automatic wait_cnt(input logic [15:0] c);
		int k;
		k = 0;
		while (cnt_m !== c && k < 1000)
		begin
			cyc(1);
			k++;
		end
		if (k == 1000)
		begin
			failures++;
			close_out();
		end
		chk("count", count, c);
	endtask : wait_cnt

	task automatic wr(input int ch, input logic [15:0] d);
		wr_en[ch] = 1'h1;
		wr_data = d;
		cyc(1);
		wr_en = '0;
		chk("value", value[ch], d);
		cyc(1);
	endtask : wr

	task automatic clr_flag(input int ch);
		flag_clr[ch] = 1'h1;
		cyc(1);
		flag_clr = '0;
	endtask : clr_flag

	initial
	begin
		cyc(16);
		chk("rst count", count, 16'h0000);
		chk("rst oe", pin_oe_n, 16'h000f);
		chk("rst flags", {chan_flag, ovf_flag, pin_out, active_sel}, 16'h0000);
		rst = 1'h0;
		run = 1'h1;
		ovf_ie = 1'h1;
		cyc(4);
		foreach (rows[i])
		begin
			cfg[rows[i].ch] = '{1'h0, 1'h0, rows[i].es, 1'h0, 1'h1};
			src[rows[i].ch] = ~rows[i].rise;
			cyc(3);
			wr(rows[i].ch, 16'hbeef);
			clr_flag(rows[i].ch);
			src[rows[i].ch] = rows[i].rise;
			exp_v = rows[i].cap ? cnt_m : 16'hbeef;
			cyc(2);
			chk("cap value", value[rows[i].ch], exp_v);
			chk("cap flag", chan_flag[rows[i].ch], rows[i].cap);
			chk("cap irq", chan_irq[rows[i].ch], rows[i].cap);
			$display("capture row %0d done", i);
		end
		wr(1, 16'h0040);
		for (int k = 0; k < 4; k++)
		begin
			cfg[1] = '{1'h0, 1'h1, acts[k], 1'h0, 1'h1};
			clr_flag(1);
			wait_cnt(16'h0040);
			cyc(3);
			chk("cmp pin", pin_out[1], pexp[k]);
			chk("cmp oe", pin_oe_n[1], 16'h0000);
			chk("cmp irq", chan_irq[1], 16'h0001);
		end
		wait_cnt(16'h0038);
		wr(1, 16'h0030);
		clr_flag(1);
		wait_cnt(16'h0050);
		chk("late write", chan_flag[1], 16'h0000);
		// Larger value written from the overflow request
		wait_cnt(16'h0000);
		chk("ovf req", ovf_irq, 16'h0001);
		wr(1, 16'h0060);
		clr_flag(1);
		wait_cnt(16'h0062);
		chk("larger", chan_flag[1], 16'h0001);
		// Smaller value written from the compare request
		chk("cmp req", chan_irq[1], 16'h0001);
		wr(1, 16'h0020);
		clr_flag(1);
		wait_cnt(16'h0022);
		chk("smaller", chan_flag[1], 16'h0001);
		$display("compare test done");
		// PWM: clear on compare, toggle on overflow, never toggle on compare
		cfg[2] = '{1'h0, 1'h1, ACT_CLEAR, 1'h1, 1'h0};
		cfg[3] = '{1'h0, 1'h1, ACT_CLEAR, 1'h0, 1'h0};
		wr(2, 16'h0080);
		wr(3, 16'h0010);
		wait_cnt(16'h0000);
		cyc(256);
		hi2 = 0;
		hi3 = 0;
		ups = 0;
		prev = pin_out[2];
		repeat (256)
		begin
			cyc(1);
			hi2 += int'(pin_out[2]);
			hi3 += int'(pin_out[3]);
			ups += int'(pin_out[2] & ~prev);
			prev = pin_out[2];
		end
		chk("pwm high", 16'(hi2), 16'h0080);
		chk("pwm period", 16'(ups), 16'h0001);
		chk("no tov", 16'(hi3), 16'h0000);
		wait_cnt(16'h0010);
		ovf_clr = 1'h1;
		cyc(1);
		ovf_clr = 1'h0;
		chk("ovf clr", ovf_flag, 16'h0000);
		wait_cnt(16'h00ff);
		chk("ovf early", ovf_flag, 16'h0000);
		cyc(2);
		chk("ovf flag", {ovf_flag, ovf_irq}, 16'h0003);
		$display("pwm test done");
		for (int p = 0; p < 2; p++)
		begin
			e = 2 * p;
			wr(e, 16'h0020);
			// Link bit wins over a capture mode bit
			cfg[e] = '{1'h1, 1'h0, ACT_SET, 1'h0, 1'h0};
			cfg[e + 1] = '{1'h0, 1'h1, ACT_SET, 1'h0, 1'h1};
			cyc(2);
			chk("link sel", active_sel[p], 16'h0000);
			chk("link oe", {pin_oe_n[e + 1], pin_oe_n[e]}, 16'h0002);
			wait_cnt(16'h0030);
			// Only the inactive odd register is written
			wr(e + 1, 16'h0090);
			cyc(2);
			chk("sel early", active_sel[p], 16'h0000);
			wait_cnt(16'h00ff);
			cyc(3);
			chk("sel swap", active_sel[p], 16'h0001);
			wait_cnt(16'h0008);
			// Odd flag left over from earlier compare runs
			flag_clr[e + 1] = 1'h1;
			clr_flag(e);
			wait_cnt(16'h0050);
			chk("old val", chan_flag[e], 16'h0000);
			wait_cnt(16'h0098);
			chk("new val", {chan_flag[e + 1], chan_flag[e]}, 16'h0001);
			$display("pair %0d done", p);
		end
		close_out();
	end
endmodule : tcp_timer_channels_tb
